/* File: tb/adcso_rx_model.sv */
// receiver model: frames and captures the lanes of both banks
`timescale 1ns/10ps
`default_nettype none
module adcso_rx_model (
  // link clock and word length
  input wire logic link_clk_i,
  input wire logic [4:0] nbits_i,
  // clocks, enables and lanes
  input wire logic bclk_i,
  input wire logic [1:0] fclk_i,
  input wire logic [1:0] oe_i,
  input wire logic [15:0] lanes_i,
  // captured words and counts
  output logic [15:0][13:0] word_o,
  output int words_o,
  output int ratio_o
);
  // --------
  // capture
  // --------
  logic [1:0] f_q = 2'h0;
  logic b_q = 1'b0;
  logic [15:0][13:0] sh;
  int cnt [2] = '{0, 0};
  int rises = 0;
  initial words_o = 0;
  // mid-bit sampling stands in for capture on both bit clock edges
  always @(negedge link_clk_i) begin
    if (fclk_i[0] && !f_q[0]) begin
      ratio_o = rises;
      rises = 0;
    end
    if (bclk_i && !b_q) rises++;
    b_q = bclk_i;
    for (int b = 0; b < 2; b++) begin
      // each bank is framed by its own frame clock only
      if (fclk_i[b] && !f_q[b]) cnt[b] = 0;
      for (int l = 8 * b; l < 8 * b + 8; l++) begin
        if (cnt[b] == 0) sh[l] = '0;
        sh[l] = {sh[l][12:0], lanes_i[l]};
        if (oe_i[b] && cnt[b] == nbits_i - 1) word_o[l] = sh[l];
      end
      if (oe_i[b] && cnt[b] == nbits_i - 1 && b == 0) words_o++;
      cnt[b]++;
      f_q[b] = fclk_i[b];
    end
  end
endmodule
`default_nettype wire

/* File: tb/adcso_top_assertions.sv */
// checker: port properties of the serial output block
`timescale 1ns/10ps
`default_nettype none
module adcso_top_assertions #(
  parameter int WAKE_SHIFT = 4
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // register writes
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // power and drive
  input wire logic ref_power_o,
  input wire logic bias_power_o,
  input wire logic [2:0] power_level_o,
  input wire logic reduced_swing_o,
  input wire logic [7:0] drive_level_o,
  // lane clocks and enables
  input wire logic bank_one_bit_clock_o,
  input wire logic bank_one_frame_clock_o,
  input wire logic bank_one_oe_o,
  input wire logic bank_two_bit_clock_o,
  input wire logic bank_two_frame_clock_o,
  input wire logic bank_two_oe_o
);
  import adcso_pkg::*;
  // --------
  // properties
  // --------
  property p_drive;
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADCSO_OFF_DRIVE |=> ##1 drive_level_o == $past(reg_wdata_i, 2);
  endproperty
  a_drive: assert property (p_drive) else $error("drive level wrong");
  property p_swing;
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADCSO_OFF_OUT_MODE |=> ##1 reduced_swing_o == $past(reg_wdata_i[1], 2);
  endproperty
  a_swing: assert property (p_swing) else $error("swing mode wrong");
  property p_level;
    @(posedge clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADCSO_OFF_POWER |=> ##1 power_level_o == $past(reg_wdata_i[2:0], 2);
  endproperty
  a_level: assert property (p_level) else $error("power level wrong");
  property p_down;
    @(posedge clk_i) disable iff (rst_i)
    power_level_o == ADCSO_PM_DOWN |-> ##[0:4] (!ref_power_o && !bias_power_o);
  endproperty
  a_down: assert property (p_down) else $error("down mode left power on");
  property p_stby;
    @(posedge clk_i) disable iff (rst_i)
    power_level_o == ADCSO_PM_STANDBY |-> ##[0:4] (ref_power_o && !bias_power_o);
  endproperty
  a_stby: assert property (p_stby) else $error("standby power wrong");
  property p_tri;
    @(posedge link_clk_i) disable iff (rst_i)
    !ref_power_o [*8] |-> !bank_one_oe_o && !bank_two_oe_o;
  endproperty
  a_tri: assert property (p_tri) else $error("drivers on while down");
  property p_share;
    @(posedge link_clk_i) disable iff (rst_i)
    bank_one_bit_clock_o == bank_two_bit_clock_o && bank_one_frame_clock_o == bank_two_frame_clock_o;
  endproperty
  a_share: assert property (p_share) else $error("bank clocks differ");
  property p_frame;
    @(posedge link_clk_i) disable iff (rst_i)
    $rose(bank_one_frame_clock_o) |-> bank_one_bit_clock_o ##0 bank_one_frame_clock_o [*6];
  endproperty
  a_frame: assert property (p_frame) else $error("frame mark wrong");
endmodule
bind adcso_top adcso_top_assertions #(.WAKE_SHIFT(WAKE_SHIFT)) adcso_top_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .ref_power_o(ref_power_o), .bias_power_o(bias_power_o),
  .power_level_o(power_level_o), .reduced_swing_o(reduced_swing_o), .drive_level_o(drive_level_o),
  .bank_one_bit_clock_o(bank_one_bit_clock_o), .bank_one_frame_clock_o(bank_one_frame_clock_o),
  .bank_one_oe_o(bank_one_oe_o), .bank_two_bit_clock_o(bank_two_bit_clock_o),
  .bank_two_frame_clock_o(bank_two_frame_clock_o), .bank_two_oe_o(bank_two_oe_o));
`default_nettype wire

/* File: tb/adcso_top_tb.sv */
// testbench: registers, lane words, coding and power modes
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, (e), (s)); end end
module adcso_top_tb;
  import adcso_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lclk = 1'b0;
  logic sclk = 1'b0;
  logic pdn = 1'b0;
  logic [15:0][13:0] code = '0;
  logic [8:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] nbits = 5'h0e;
  logic [7:0] rdata, drv;
  logic refp, biasp, clkrun, swing;
  logic [2:0] plev;
  logic [1:0] bck, fck, oe;
  logic [15:0] lanes;
  logic [15:0][13:0] word;
  int words, ratio;
  int err_total = 0;
  int checked = 0;
  int shalf = 7;
  int scnt = 0;
  // --------
  // clocks and instances
  // --------
  always #12.5 clk_i = ~clk_i;
  initial begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end
  // sample clock is link/14 so the words lock to it
  always @(posedge lclk) begin
    scnt <= (scnt + 1) % (2 * shalf);
    if (scnt == 0 || scnt == shalf) sclk <= ~sclk;
  end
  adcso_top #(.WAKE_SHIFT(2)) adcso_top_inst (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(lclk),
    .sample_clk_i(sclk), .power_down_pin_i(pdn), .adc_code_i(code), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ref_power_o(refp),
    .bias_power_o(biasp), .core_clk_run_o(clkrun), .power_level_o(plev), .reduced_swing_o(swing),
    .drive_level_o(drv), .bank_one_bit_clock_o(bck[0]), .bank_one_frame_clock_o(fck[0]),
    .bank_one_data_lanes_o(lanes[7:0]), .bank_one_oe_o(oe[0]), .bank_two_bit_clock_o(bck[1]),
    .bank_two_frame_clock_o(fck[1]), .bank_two_data_lanes_o(lanes[15:8]), .bank_two_oe_o(oe[1]));
  adcso_rx_model adcso_rx_model_inst (.link_clk_i(lclk), .nbits_i(nbits), .bclk_i(bck[0]),
    .fclk_i(fck), .oe_i(oe), .lanes_i(lanes), .word_o(word), .words_o(words), .ratio_o(ratio));
  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    `CHK("register", e, rdata & m)
  endtask
  // bounded wait for whole captured words
  task automatic wwords(input int n);
    int t;
    t = words + n;
    for (int i = 0; i < 4000 && words < t; i++) @(posedge lclk);
    if (words < t) begin
      err_total++;
      final_report();
    end
  endtask
  function automatic logic [13:0] xf(input logic [13:0] c, input logic ob, input logic lsb, input logic sh);
    logic [13:0] t;
    logic [13:0] r;
    t = ob ? c : {~c[13], c[12:0]};
    for (int i = 0; i < 14; i++) r[i] = t[13-i];
    if (lsb) t = r;
    return sh ? {2'h0, lsb ? t[11:0] : t[13:2]} : t;
  endfunction
  task automatic lchk(input logic ob, input logic lsb, input logic sh);
    wwords(4);
    for (int l = 0; l < 16; l++) `CHK("lane word", xf(code[l], ob, lsb, sh), word[l])
  endtask
  // --------
  // sequence
  // --------
  initial begin
    @(posedge clk_i);
    code[0] <= 14'h2000;
    code[1] <= 14'h0000;
    code[2] <= 14'h3fff;
    for (int l = 3; l < 16; l++) code[l] <= 14'h0a5c ^ (14'(l) * 14'h0321);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(ADCSO_OFF_CLOCK, ADCSO_RST_CLOCK);
    rchk(ADCSO_OFF_DRIVE, 8'h00);
    rchk(ADCSO_OFF_OUT_MODE, 8'h00);
    rchk(ADCSO_OFF_POWER, 8'h00);
    rchk(9'h055, 8'h00);
    wreg(ADCSO_OFF_DRIVE, 8'ha5);
    rchk(ADCSO_OFF_DRIVE, 8'ha5);
    `CHK("drive", 8'ha5, drv)
    lchk(0, 0, 0);
    `CHK("bit clocks per word", 7, ratio)
    wreg(ADCSO_OFF_OUT_MODE, 8'h01);
    lchk(1, 0, 0);
    wreg(ADCSO_OFF_OUT_MODE, 8'h02);
    repeat (2) @(posedge clk_i);
    `CHK("swing", 1'b1, swing)
    wreg(ADCSO_OFF_SERIAL, 8'h01);
    lchk(0, 1, 0);
    wreg(ADCSO_OFF_SERIAL, 8'h02);
    nbits <= 5'h0c;
    shalf = 6;
    lchk(0, 0, 1);
    wreg(ADCSO_OFF_SERIAL, 8'h03);
    lchk(0, 1, 1);
    wreg(ADCSO_OFF_SERIAL, 8'h00);
    nbits <= 5'h0e;
    shalf = 7;
    repeat (200) @(posedge clk_i);
    rchk(ADCSO_OFF_STATUS, 8'h09, 8'h0f);
    wreg(ADCSO_OFF_CLOCK, 8'h00);
    rchk(ADCSO_OFF_STATUS, 8'h08, 8'h09);
    lchk(0, 0, 0);
    wreg(ADCSO_OFF_CLOCK, 8'h01);
    // a rate change drops lock; relock is given the full 5 us
    shalf = 5;
    repeat (300) @(posedge clk_i);
    rchk(ADCSO_OFF_STATUS, 8'h00, 8'h01);
    shalf = 7;
    repeat (200) @(posedge clk_i);
    rchk(ADCSO_OFF_STATUS, 8'h01, 8'h01);
    for (int m = 1; m < 3; m++) begin
      wreg(ADCSO_OFF_POWER, m[7:0]);
      repeat (20) @(posedge clk_i);
      `CHK("oe", 2'b00, oe)
      `CHK("reference", m == 2, refp)
      `CHK("bias and clock", 2'b00, {biasp, clkrun})
      rchk(ADCSO_OFF_STATUS, (m == 1) ? 8'h02 : 8'h04, 8'h0e);
      wreg(ADCSO_OFF_POWER, 8'h00);
      wwords(2);
      `CHK("oe", 2'b11, oe)
    end
    @(posedge clk_i);
    pdn <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK("oe", 2'b00, oe)
    `CHK("reference", 1'b0, refp)
    pdn <= 1'b0;
    wwords(2);
    `CHK("oe", 2'b11, oe)
    final_report();
  end
endmodule
`default_nettype wire

/* File: verilog/adcso_pkg.sv */
// package: constants and types for the serial output and power control block
package adcso_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADCSO_LANES = 16;
  localparam int ADCSO_BANK_LANES = 8;
  localparam int ADCSO_BITS = 14;
  localparam int ADCSO_SHORT_BITS = 12;
  localparam int ADCSO_RATIO = 7;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] ADCSO_OFF_CLOCK = 9'h009;
  localparam logic [8:0] ADCSO_OFF_STATUS = 9'h00A;
  localparam logic [8:0] ADCSO_OFF_OUT_MODE = 9'h014;
  localparam logic [8:0] ADCSO_OFF_DRIVE = 9'h015;
  localparam logic [8:0] ADCSO_OFF_SERIAL = 9'h021;
  localparam logic [8:0] ADCSO_OFF_POWER = 9'h100;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ADCSO_CLK_DCS_BIT = 0;
  localparam int ADCSO_OUT_OFFSET_BIN_BIT = 0;
  localparam int ADCSO_OUT_REDUCED_BIT = 1;
  localparam int ADCSO_SER_LSB_FIRST_BIT = 0;
  localparam int ADCSO_SER_SHORT_BIT = 1;
  localparam int ADCSO_ST_LOCKED_BIT = 0;
  localparam int ADCSO_ST_DOWN_BIT = 1;
  localparam int ADCSO_ST_STANDBY_BIT = 2;
  localparam int ADCSO_ST_READY_BIT = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCSO_RST_CLOCK = 8'h01;
  localparam logic [7:0] ADCSO_RST_OUT_MODE = 8'h00;
  localparam logic [7:0] ADCSO_RST_DRIVE = 8'h00;
  localparam logic [7:0] ADCSO_RST_SERIAL = 8'h00;
  localparam logic [7:0] ADCSO_RST_POWER = 8'h00;
  // ----------------------------------------------------------------
  // power mode codes (bits 2:0 of the power mode register)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADCSO_PM_NORMAL = 3'h0;
  localparam logic [2:0] ADCSO_PM_DOWN = 3'h1;
  localparam logic [2:0] ADCSO_PM_STANDBY = 3'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ADCSO_CLK_MHZ = 40;
  localparam int ADCSO_DCS_MIN_MHZ = 20;
  localparam int ADCSO_RELOCK_MIN_NS = 1500;
  localparam int ADCSO_RELOCK_MAX_NS = 5000;
  localparam int ADCSO_RELOCK_CYC = (ADCSO_RELOCK_MIN_NS * ADCSO_CLK_MHZ + 999) / 1000;
  localparam int ADCSO_WAKE_SHIFT = 4;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic offset_bin;
    logic lsb_first;
    logic short_word;
    logic dcs_on;
    logic outputs_off;
  } adcso_link_cfg_t;

  typedef enum logic [3:0] {
    ADCSO_ST_NORMAL = 4'b0001,
    ADCSO_ST_STBY = 4'b0010,
    ADCSO_ST_DOWN = 4'b0100,
    ADCSO_ST_WAKE = 4'b1000
  } adcso_pwr_state_t;
endpackage

/* File: verilog/adcso_top.sv */
// serial lane output, duty cycle regeneration, coding and power control
//
// Operation
// RL1 - with stabilizer on, frame clock is regenerated at 50% duty from rising edges
// RL2 - regeneration is only guaranteed above 20 MHz sample rate; lock status reflects it
// RL3 - software waits 1.5 to 5 us after a rate change before trusting samples
// RL4 - power mode register bits 2:0 select the power saving mode
// RL5 - power-down by register or while the pin is high; pin low returns normal
// RL6 - while powered down all data and clock drivers are tri-stated
// RL7 - standby keeps the reference powered and shuts down the rest
// RL8 - outputs start at standard drive; a register bit selects reduced swing
// RL9 - drive-strength register raises current on all 16 lane drivers together
// RL10 - twos complement by default; a register bit selects offset binary
// RL11 - codes saturate; twos complement is offset binary with the sign bit inverted
// RL12 - each converter gets its own lane, two bits per bit clock period
// RL13 - bit clock runs at seven times the sample clock by default
// RL14 - receiver samples lanes on both bit clock edges
// RL15 - first clock pair serves bank one lanes, second pair bank two lanes
// RL16 - frame clock toggles at sample rate and marks each new word
// RL17 - power-down stops reference, bias and clock; wake time grows with down time
// RL18 - msb first by default; a register bit sends lsb first
// RL19 - a register bit shortens each word to 12 bits
// RL20 - frame clock rise coincides with the first bit of each word
// RL21 - all lanes of a bank share bit clock, frame clock and word boundaries
`timescale 1ns/10ps
`default_nettype none
module adcso_top #(
  parameter int WAKE_SHIFT = adcso_pkg::ADCSO_WAKE_SHIFT
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link clock: two link cycles per bit clock period
  input wire logic link_clk_i,
  // sample clock and power-down pins
  input wire logic sample_clk_i,
  input wire logic power_down_pin_i,
  // converter codes, offset binary, on the link clock
  input wire logic [adcso_pkg::ADCSO_LANES-1:0][adcso_pkg::ADCSO_BITS-1:0] adc_code_i,
  // register port
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // analog power and drive controls
  output logic ref_power_o,
  output logic bias_power_o,
  output logic core_clk_run_o,
  output logic [2:0] power_level_o,
  output logic reduced_swing_o,
  output logic [7:0] drive_level_o,
  // bank one
  output logic bank_one_bit_clock_o,
  output logic bank_one_frame_clock_o,
  output logic [adcso_pkg::ADCSO_BANK_LANES-1:0] bank_one_data_lanes_o,
  output logic bank_one_oe_o,
  // bank two
  output logic bank_two_bit_clock_o,
  output logic bank_two_frame_clock_o,
  output logic [adcso_pkg::ADCSO_BANK_LANES-1:0] bank_two_data_lanes_o,
  output logic bank_two_oe_o
);
  import adcso_pkg::*;

  // ----------------------------------------------------------------
  // registers (system clock)
  // ----------------------------------------------------------------
  logic [7:0] clock_reg, out_mode_reg, drive_reg, serial_reg, power_reg;
  logic locked_reg, pd_pin_reg;
  adcso_pwr_state_t state_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_reg <= ADCSO_RST_CLOCK;
      out_mode_reg <= ADCSO_RST_OUT_MODE;
      drive_reg <= ADCSO_RST_DRIVE;
      serial_reg <= ADCSO_RST_SERIAL;
      power_reg <= ADCSO_RST_POWER;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADCSO_OFF_CLOCK: clock_reg <= reg_wdata_i;
        ADCSO_OFF_OUT_MODE: out_mode_reg <= reg_wdata_i;
        ADCSO_OFF_DRIVE: drive_reg <= reg_wdata_i;
        ADCSO_OFF_SERIAL: serial_reg <= reg_wdata_i;
        ADCSO_OFF_POWER: power_reg <= {5'h00, reg_wdata_i[2:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADCSO_OFF_CLOCK: reg_rdata_o <= clock_reg;
        ADCSO_OFF_OUT_MODE: reg_rdata_o <= out_mode_reg;
        ADCSO_OFF_DRIVE: reg_rdata_o <= drive_reg;
        ADCSO_OFF_SERIAL: reg_rdata_o <= serial_reg;
        ADCSO_OFF_POWER: reg_rdata_o <= power_reg;
        ADCSO_OFF_STATUS: begin
          reg_rdata_o <= 8'h00;
          reg_rdata_o[ADCSO_ST_LOCKED_BIT] <= locked_reg;
          reg_rdata_o[ADCSO_ST_DOWN_BIT] <= (state_reg == ADCSO_ST_DOWN);
          reg_rdata_o[ADCSO_ST_STANDBY_BIT] <= (state_reg == ADCSO_ST_STBY);
          reg_rdata_o[ADCSO_ST_READY_BIT] <= (state_reg == ADCSO_ST_NORMAL);
        end
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // drive options apply to all lanes together
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reduced_swing_o <= 1'b0;
      drive_level_o <= ADCSO_RST_DRIVE;
    end else begin
      reduced_swing_o <= out_mode_reg[ADCSO_OUT_REDUCED_BIT]; // [RL8]
      drive_level_o <= drive_reg; // [RL9]
    end
  end

  // ----------------------------------------------------------------
  // power-down pin synchroniser (three stages, second and third agree)
  // ----------------------------------------------------------------
  logic [2:0] pd_sync_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_sync_reg <= 3'b000;
      pd_pin_reg <= 1'b0;
    end else begin
      pd_sync_reg <= {pd_sync_reg[1:0], power_down_pin_i};
      if (pd_sync_reg[1] == pd_sync_reg[2]) begin
        pd_pin_reg <= pd_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  logic [15:0] down_time_reg, wake_cnt_reg;
  logic want_down, want_stby;

  assign want_down = pd_pin_reg || (power_reg[2:0] == ADCSO_PM_DOWN); // [RL5]
  assign want_stby = (power_reg[2:0] == ADCSO_PM_STANDBY); // [RL7]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ADCSO_ST_NORMAL;
      down_time_reg <= 16'h0000;
      wake_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ADCSO_ST_NORMAL: begin
          down_time_reg <= 16'h0000;
          if (want_down) begin
            state_reg <= ADCSO_ST_DOWN;
          end else if (want_stby) begin
            state_reg <= ADCSO_ST_STBY;
          end
        end
        ADCSO_ST_STBY: begin
          // reference stayed up, so wake is immediate
          if (want_down) begin
            state_reg <= ADCSO_ST_DOWN;
          end else if (!want_stby) begin
            state_reg <= ADCSO_ST_WAKE;
            wake_cnt_reg <= 16'h0000;
          end
        end
        ADCSO_ST_DOWN: begin
          if (down_time_reg != 16'hFFFF) begin
            down_time_reg <= down_time_reg + 16'h0001;
          end
          if (!want_down) begin
            // capacitors drained longer need longer to recharge
            wake_cnt_reg <= down_time_reg >> WAKE_SHIFT; // [RL17]
            state_reg <= want_stby ? ADCSO_ST_STBY : ADCSO_ST_WAKE;
          end
        end
        ADCSO_ST_WAKE: begin
          if (want_down) begin
            state_reg <= ADCSO_ST_DOWN;
          end else if (wake_cnt_reg == 16'h0000) begin
            state_reg <= ADCSO_ST_NORMAL;
          end else begin
            wake_cnt_reg <= wake_cnt_reg - 16'h0001;
          end
        end
        default: state_reg <= ADCSO_ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_power_o <= 1'b1;
      bias_power_o <= 1'b1;
      core_clk_run_o <= 1'b1;
      power_level_o <= ADCSO_PM_NORMAL;
    end else begin
      ref_power_o <= (state_reg != ADCSO_ST_DOWN); // [RL17] [RL7]
      bias_power_o <= (state_reg == ADCSO_ST_NORMAL) || (state_reg == ADCSO_ST_WAKE); // [RL17]
      core_clk_run_o <= (state_reg == ADCSO_ST_NORMAL) || (state_reg == ADCSO_ST_WAKE); // [RL17]
      power_level_o <= power_reg[2:0]; // [RL4]
    end
  end

  // ----------------------------------------------------------------
  // lock status back from the link side, qualified by relock time
  // ----------------------------------------------------------------
  logic [2:0] lock_sync_reg;
  logic lock_lvl_reg;
  logic [7:0] relock_cnt_reg;
  logic link_locked_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_sync_reg <= 3'b000;
      lock_lvl_reg <= 1'b0;
    end else begin
      lock_sync_reg <= {lock_sync_reg[1:0], link_locked_reg};
      if (lock_sync_reg[1] == lock_sync_reg[2]) begin
        lock_lvl_reg <= lock_sync_reg[2];
      end
    end
  end

  // lock is reported only once it has held for the shortest relock time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      relock_cnt_reg <= 8'h00;
      locked_reg <= 1'b0;
    end else if (!lock_lvl_reg || !clock_reg[ADCSO_CLK_DCS_BIT]) begin
      relock_cnt_reg <= 8'h00;
      locked_reg <= 1'b0;
    end else if (relock_cnt_reg == 8'(ADCSO_RELOCK_CYC - 1)) begin
      locked_reg <= 1'b1; // [RL3]
    end else begin
      relock_cnt_reg <= relock_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // configuration into the link domain
  // ----------------------------------------------------------------
  adcso_link_cfg_t cfg_src, cfg_reg;
  logic [$bits(adcso_link_cfg_t)-1:0] cfg_s1_reg, cfg_s2_reg, cfg_s3_reg;

  assign cfg_src.offset_bin = out_mode_reg[ADCSO_OUT_OFFSET_BIN_BIT];
  assign cfg_src.lsb_first = serial_reg[ADCSO_SER_LSB_FIRST_BIT];
  assign cfg_src.short_word = serial_reg[ADCSO_SER_SHORT_BIT];
  assign cfg_src.dcs_on = clock_reg[ADCSO_CLK_DCS_BIT];
  assign cfg_src.outputs_off = (state_reg != ADCSO_ST_NORMAL);

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_s1_reg <= '0;
      cfg_s2_reg <= '0;
      cfg_s3_reg <= '0;
    end else begin
      cfg_s1_reg <= cfg_src;
      cfg_s2_reg <= cfg_s1_reg;
      cfg_s3_reg <= cfg_s2_reg;
    end
  end

  // each bit settles on its own once the last two stages agree
  genvar gc;
  generate
    for (gc = 0; gc < $bits(adcso_link_cfg_t); gc++) begin : g_cfg
      always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cfg_reg[gc] <= 1'b1;
        end else if (cfg_s2_reg[gc] == cfg_s3_reg[gc]) begin
          cfg_reg[gc] <= cfg_s3_reg[gc];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // link domain: word timing from the sample clock
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync_reg;
  logic sclk_lvl_reg, sclk_prev_reg, sclk_rise;
  logic [3:0] bit_cnt_reg, bit_cnt_next, last_idx, half_len;
  logic word_start;

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 3'b000;
      sclk_lvl_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sample_clk_i};
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
        sclk_lvl_reg <= sclk_sync_reg[2];
      end
      sclk_prev_reg <= sclk_lvl_reg;
    end
  end

  assign sclk_rise = sclk_lvl_reg && !sclk_prev_reg;
  assign last_idx = cfg_reg.short_word ? 4'(ADCSO_SHORT_BITS - 1) : 4'(ADCSO_BITS - 1); // [RL19]
  assign half_len = cfg_reg.short_word ? 4'(ADCSO_SHORT_BITS / 2) : 4'(ADCSO_RATIO); // [RL13]
  // a sample clock rise restarts the word; without one the word free-runs
  assign word_start = sclk_rise || (bit_cnt_reg == last_idx); // [RL16]
  assign bit_cnt_next = word_start ? 4'h0 : bit_cnt_reg + 4'h1;

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 4'h0;
      link_locked_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      // a slow input clock lets the counter wrap early and drops lock
      if (word_start) begin
        link_locked_reg <= sclk_rise && (bit_cnt_reg == last_idx); // [RL2]
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: coding and serialisation
  // ----------------------------------------------------------------
  logic [ADCSO_LANES-1:0][ADCSO_BITS-1:0] word_reg, word_src;
  logic [3:0] bit_idx;
  logic [ADCSO_LANES-1:0] lane_reg;
  logic [1:0] bit_clk_reg, frame_reg, oe_reg;

  // msb first by default; the short word drops the two lowest bits
  always_comb begin
    if (!cfg_reg.lsb_first) begin
      bit_idx = 4'(ADCSO_BITS - 1) - bit_cnt_next; // [RL18]
    end else if (cfg_reg.short_word) begin
      bit_idx = bit_cnt_next + 4'(ADCSO_BITS - ADCSO_SHORT_BITS); // [RL19]
    end else begin
      bit_idx = bit_cnt_next; // [RL18]
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < ADCSO_LANES; gl++) begin : g_lane
      // core codes already clamp at the rails; only the sign bit flips
      assign word_src[gl] = word_start ?
        {adc_code_i[gl][ADCSO_BITS-1] ^ !cfg_reg.offset_bin, adc_code_i[gl][ADCSO_BITS-2:0]} :
        word_reg[gl]; // [RL10] [RL11]

      always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
          word_reg[gl] <= '0;
          lane_reg[gl] <= 1'b0;
        end else begin
          word_reg[gl] <= word_src[gl]; // [RL21]
          lane_reg[gl] <= word_src[gl][bit_idx]; // [RL12] [RL14]
        end
      end
    end
  endgenerate

  // one register pair per bank drives each clock set from the same shared word timing
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
          bit_clk_reg[gb] <= 1'b0;
          frame_reg[gb] <= 1'b0;
          oe_reg[gb] <= 1'b0;
        end else begin
          // even bits on the rising edge, odd bits on the falling edge
          bit_clk_reg[gb] <= !bit_cnt_next[0]; // [RL13] [RL14]
          if (cfg_reg.dcs_on) begin
            if (word_start || bit_cnt_next >= half_len) begin
              frame_reg[gb] <= word_start; // [RL1] [RL20]
            end
          end else begin
            frame_reg[gb] <= sclk_lvl_reg; // [RL16]
          end
          oe_reg[gb] <= !cfg_reg.outputs_off; // [RL6] [RL7]
        end
      end
    end
  endgenerate

  assign bank_one_bit_clock_o = bit_clk_reg[0]; // [RL15]
  assign bank_one_frame_clock_o = frame_reg[0];
  assign bank_one_data_lanes_o = lane_reg[ADCSO_BANK_LANES-1:0];
  assign bank_one_oe_o = oe_reg[0];
  assign bank_two_bit_clock_o = bit_clk_reg[1]; // [RL15]
  assign bank_two_frame_clock_o = frame_reg[1];
  assign bank_two_data_lanes_o = lane_reg[ADCSO_LANES-1:ADCSO_BANK_LANES];
  assign bank_two_oe_o = oe_reg[1];
endmodule
`default_nettype wire
